// ### common/api_timer_pkg.sv
// package: register map, field positions and timing for the wakeup timer
// assumes a 32-bit axi4-lite slave with word-aligned registers
package api_timer_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_RATE   = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK   = 8'h0C;
  localparam logic [7:0] OFF_COUNT  = 8'h10;

  // control field positions
  localparam int CTRL_CLK_SEL  = 7;
  localparam int CTRL_WAVE_SEL = 4;
  localparam int CTRL_EXT_EN   = 3;
  localparam int CTRL_FEAT_EN  = 2;
  localparam int CTRL_IRQ_EN   = 1;
  localparam int CTRL_FLAG     = 0;
  localparam logic [7:0] CTRL_WMASK = 8'h9E;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // status bit positions
  localparam int ST_TIMEOUT = 0;
  localparam int ST_WIDTH   = 1;

  // rate and period
  localparam logic [15:0] RATE_RESET = 16'h0000;
  // autonomous clock divider: one enable per this many bus cycles
  localparam int ACLK_DIV = 100;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic clk_sel;
    logic wave_sel;
    logic ext_en;
    logic feat_en;
    logic irq_en;
  } ctrl_t;

endpackage

// ### design/tick_divider.sv
// divider: one-cycle enable every DIV cycles of clk_i
// assumes a single clock and synchronous reset
module tick_divider
  import api_timer_pkg::*;
#(
  parameter int DIV = ACLK_DIV
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // enable
  output logic      tick_o
);

  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_ff;

  initial begin
    if (DIV < 1) $error("tick_divider: DIV must be at least 1");
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || cnt_ff == LAST) cnt_ff <= '0;
    else                          cnt_ff <= cnt_ff + W'(1);
  end

  assign tick_o = (DIV == 1) ? 1'b1 : (cnt_ff == LAST);

endmodule

// ### design/api_timer.sv
// periodic wakeup timer with axi4-lite registers and an external waveform
// assumes clk_i is the bus clock; the autonomous clock is a divided enable
module api_timer
  import api_timer_pkg::*;
#(
  parameter int RATE_W = 16,
  parameter int DIV    = ACLK_DIV
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // axi4-lite write address
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  // axi4-lite write data
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  // axi4-lite write response
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  // axi4-lite read address
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  // axi4-lite read data
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  // pin and interrupt
  output logic             periodic_waveform_pin_o,
  output logic             irq_o
);

  initial begin
    if (RATE_W < 1 || RATE_W > 16) $error("api_timer: RATE_W 1..16");
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  // registers
  ctrl_t              ctrl_ff;
  logic [RATE_W-1:0]  period_rate_value_ff;
  logic [ST_WIDTH-1:0] status_ff;
  logic [ST_WIDTH-1:0] mask_ff;
  logic [RATE_W:0]    cnt_ff;
  logic               wave_ff;
  logic               pulse_ff;

  // write channel capture
  logic        aw_have_ff;
  logic        w_have_ff;
  logic [7:0]  aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;

  assign awready_o = !aw_have_ff && !bvalid_ff;
  assign wready_o  = !w_have_ff && !bvalid_ff;
  assign arready_o = !rvalid_ff;
  assign bvalid_o  = bvalid_ff;
  assign bresp_o   = bresp_ff;
  assign rvalid_o  = rvalid_ff;
  assign rdata_o   = rdata_ff;
  assign rresp_o   = rresp_ff;

  wire aw_take = awvalid_i && awready_o;
  wire w_take  = wvalid_i && wready_o;
  wire [7:0]  wa = aw_have_ff ? aw_addr_ff : awaddr_i;
  wire [31:0] wd = w_have_ff ? w_data_ff : wdata_i;
  wire [3:0]  ws = w_have_ff ? w_strb_ff : wstrb_i;
  wire wr_go = (aw_have_ff || aw_take) && (w_have_ff || w_take);

  wire wr_ctrl   = wr_go && hit(wa, OFF_CTRL) && ws[0];
  wire wr_rate   = wr_go && hit(wa, OFF_RATE);
  wire wr_status = wr_go && hit(wa, OFF_STATUS) && ws[0];
  wire wr_mask   = wr_go && hit(wa, OFF_MASK) && ws[0];
  wire wr_mapped = hit(wa, OFF_CTRL) || hit(wa, OFF_RATE) ||
                   hit(wa, OFF_STATUS) || hit(wa, OFF_MASK) ||
                   hit(wa, OFF_COUNT);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
    end else begin
      if (wr_go) aw_have_ff <= 1'b0;
      else if (aw_take) aw_have_ff <= 1'b1;
      if (wr_go) w_have_ff <= 1'b0;
      else if (w_take) w_have_ff <= 1'b1;
      if (aw_take) aw_addr_ff <= awaddr_i;
      if (w_take) begin
        w_data_ff <= wdata_i;
        w_strb_ff <= wstrb_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bready_i) begin
      bvalid_ff <= 1'b0;
    end
  end

  // control register
  wire [7:0] cw = wd[7:0];
  ctrl_t nxt_ctrl;
  always_comb begin
    nxt_ctrl          = ctrl_ff;
    nxt_ctrl.wave_sel = cw[CTRL_WAVE_SEL];
    nxt_ctrl.ext_en   = cw[CTRL_EXT_EN];
    nxt_ctrl.feat_en  = cw[CTRL_FEAT_EN];
    nxt_ctrl.irq_en   = cw[CTRL_IRQ_EN];
    if (!ctrl_ff.feat_en && !cw[CTRL_FEAT_EN])
      nxt_ctrl.clk_sel = cw[CTRL_CLK_SEL];
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) ctrl_ff <= ctrl_t'(CTRL_RESET[7:3]);
    else if (wr_ctrl) ctrl_ff <= nxt_ctrl;
  end

  // low byte lane width of the rate register
  localparam int LO_W = (RATE_W > 8) ? 8 : RATE_W;

  always_ff @(posedge clk_i) begin
    if (srst_i) period_rate_value_ff <= RATE_RESET[RATE_W-1:0];
    else if (wr_rate && ws[1]) period_rate_value_ff <= wd[RATE_W-1:0];
    else if (wr_rate && ws[0])
      period_rate_value_ff[LO_W-1:0] <= wd[LO_W-1:0];
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) mask_ff <= '0;
    else if (wr_mask) mask_ff <= wd[ST_WIDTH-1:0];
  end

  // timer clock: divided autonomous enable or every bus cycle
  logic aclk_tick;
  tick_divider #(.DIV(DIV)) u_aclk (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .tick_o (aclk_tick)
  );
  wire tick = ctrl_ff.clk_sel ? 1'b1 : aclk_tick;

  // period = 2*(rate+1) selected-clock cycles; minimum period is 2
  wire [RATE_W:0] last = {period_rate_value_ff, 1'b1};
  wire timeout = ctrl_ff.feat_en && tick && (cnt_ff == last);

  always_ff @(posedge clk_i) begin
    if (srst_i || !ctrl_ff.feat_en) cnt_ff <= '0;
    else if (tick) cnt_ff <= timeout ? '0 : cnt_ff + 1'b1;
  end

  // flag: set wins over clear
  wire flag_clr = (wr_status && wd[ST_TIMEOUT]) ||
                  (wr_ctrl && cw[CTRL_FLAG]);
  always_ff @(posedge clk_i) begin
    if (srst_i) status_ff <= '0;
    else if (timeout) status_ff[ST_TIMEOUT] <= 1'b1;
    else if (flag_clr) status_ff[ST_TIMEOUT] <= 1'b0;
  end

  assign irq_o = ctrl_ff.irq_en && |(status_ff & mask_ff);

  // waveforms: pulse lasts one selected-clock cycle (half min period)
  always_ff @(posedge clk_i) begin
    if (srst_i || !ctrl_ff.feat_en) begin
      wave_ff  <= 1'b0;
      pulse_ff <= 1'b0;
    end else begin
      if (timeout) wave_ff <= !wave_ff;
      if (timeout) pulse_ff <= 1'b1;
      else if (tick) pulse_ff <= 1'b0;
    end
  end

  wire sel_wave = ctrl_ff.wave_sel ? wave_ff : pulse_ff;
  wire pin_en   = ctrl_ff.ext_en && ctrl_ff.feat_en;
  logic pin_ff;
  always_ff @(posedge clk_i) begin
    if (srst_i) pin_ff <= 1'b0;
    else pin_ff <= pin_en && sel_wave;
  end
  assign periodic_waveform_pin_o = pin_ff;

  // read channel
  wire [7:0] ctrl_rd = {ctrl_ff.clk_sel, 2'b00, ctrl_ff.wave_sel,
                        ctrl_ff.ext_en, ctrl_ff.feat_en, ctrl_ff.irq_en,
                        status_ff[ST_TIMEOUT]};
  wire rd_mapped = hit(araddr_i, OFF_CTRL) || hit(araddr_i, OFF_RATE) ||
                   hit(araddr_i, OFF_STATUS) || hit(araddr_i, OFF_MASK) ||
                   hit(araddr_i, OFF_COUNT);
  wire [31:0] rd_mux =
    hit(araddr_i, OFF_CTRL)   ? {24'h000000, ctrl_rd} :
    hit(araddr_i, OFF_RATE)   ? 32'(period_rate_value_ff) :
    hit(araddr_i, OFF_STATUS) ? 32'(status_ff) :
    hit(araddr_i, OFF_MASK)   ? 32'(mask_ff) :
    hit(araddr_i, OFF_COUNT)  ? 32'(cnt_ff) : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end else if (arvalid_i && arready_o) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rready_i) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule

// ### dv/api_timer_monitor.sv
// checker: bus handshake and reset properties of api_timer
// assumes it is bound to api_timer and sees only its ports
module api_timer_monitor (
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic        awvalid_i,
  input wire logic        awready_o,
  input wire logic        wvalid_i,
  input wire logic        wready_o,
  input wire logic [1:0]  bresp_o,
  input wire logic        bvalid_o,
  input wire logic        bready_i,
  input wire logic        arvalid_i,
  input wire logic        arready_o,
  input wire logic [31:0] rdata_o,
  input wire logic        rvalid_o,
  input wire logic        rready_i,
  input wire logic        periodic_waveform_pin_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence wr_taken;
    awvalid_i && awready_o && wvalid_i && wready_o;
  endsequence
  sequence rd_taken;
    arvalid_i && arready_o;
  endsequence
  AST_B_ANSWER: assert property (wr_taken |=> bvalid_o)
    else $error("write not answered");
  AST_R_ANSWER: assert property (rd_taken |=> rvalid_o)
    else $error("read not answered");
  AST_B_HOLD: assert property (bvalid_o && !bready_i |=>
    bvalid_o && $stable(bresp_o))
    else $error("write response dropped");
  AST_R_HOLD: assert property (rvalid_o && !rready_i |=>
    rvalid_o && $stable(rdata_o))
    else $error("read data dropped");
  AST_B_DONE: assert property (bvalid_o && bready_i |=> !bvalid_o)
    else $error("write response repeated");
  AST_W_BLOCK: assert property (bvalid_o |-> !awready_o && !wready_o)
    else $error("write taken during response");
  AST_R_BLOCK: assert property (rvalid_o |-> !arready_o)
    else $error("read taken during response");
  AST_RST: assert property ($fell(srst_i) |->
    !irq_o && !periodic_waveform_pin_o && !bvalid_o)
    else $error("outputs active after reset");
endmodule
bind api_timer api_timer_monitor i_api_timer_monitor (
  .clk_i(clk_i), .srst_i(srst_i),
  .awvalid_i(awvalid_i), .awready_o(awready_o), .wvalid_i(wvalid_i),
  .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o),
  .bready_i(bready_i), .arvalid_i(arvalid_i), .arready_o(arready_o),
  .rdata_o(rdata_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
  .periodic_waveform_pin_o(periodic_waveform_pin_o), .irq_o(irq_o));

// ### dv/api_timer_bench.sv
// testbench: register rows, then waveform, flag and reset cases
// assumes api_timer_pkg and api_timer are compiled before it
module api_timer_bench;
  import api_timer_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {bit w; logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_t;
  logic        clk_i, srst_i, awvalid_i, wvalid_i, bready_i, arvalid_i;
  logic        rready_i, awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic        periodic_waveform_pin_o, irq_o;
  logic [7:0]  awaddr_i, araddr_i;
  logic [31:0] wdata_i, rdata_o, q;
  logic [3:0]  wstrb_i;
  logic [1:0]  bresp_o, rresp_o, s;
  int          fail_count, checks, h, l;
  row_t        rows[12] = '{
    '{1'h1, OFF_RATE, 32'hFFFF, RESP_OKAY}, '{1'h0, OFF_RATE, 32'hFFFF, RESP_OKAY},
    '{1'h0, OFF_CTRL, 32'h0, RESP_OKAY}, '{1'h1, OFF_MASK, 32'h1, RESP_OKAY},
    '{1'h0, OFF_MASK, 32'h1, RESP_OKAY}, '{1'h1, 8'h14, 32'h1, RESP_SLVERR},
    '{1'h0, 8'h14, 32'h0, RESP_SLVERR}, '{1'h1, OFF_CTRL, 32'h86, RESP_OKAY},
    '{1'h0, OFF_CTRL, 32'h6, RESP_OKAY}, '{1'h1, OFF_CTRL, 32'h0, RESP_OKAY},
    '{1'h1, OFF_CTRL, 32'h80, RESP_OKAY}, '{1'h0, OFF_CTRL, 32'h80, RESP_OKAY}};
  api_timer #(.DIV(2)) i_api_timer (.clk_i(clk_i), .srst_i(srst_i),
    .awaddr_i(awaddr_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
    .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i),
    .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o),
    .bready_i(bready_i), .araddr_i(araddr_i), .arvalid_i(arvalid_i),
    .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o),
    .rvalid_o(rvalid_o), .rready_i(rready_i), .irq_o(irq_o),
    .periodic_waveform_pin_o(periodic_waveform_pin_o));
  task automatic summarize();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // one bus transfer; valids dropped when taken, ready held until answer
  task automatic xf(input bit w, input logic [7:0] a, input logic [31:0] d);
    bit pa, pw, ta, tw, rv, dn;
    int n;
    @(posedge clk_i);
    pa = 1;
    pw = w;
    dn = 0;
    if (w) begin
      awaddr_i  <= a;
      wdata_i   <= d;
      awvalid_i <= 1'b1;
      wvalid_i  <= 1'b1;
      bready_i  <= 1'b1;
    end else begin
      araddr_i  <= a;
      arvalid_i <= 1'b1;
      rready_i  <= 1'b1;
    end
    for (n = 0; n < 60 && !dn; n++) begin
      @(negedge clk_i);
      ta = (w ? awready_o : arready_o) === 1'b1;
      tw = wready_o === 1'b1;
      rv = (w ? bvalid_o : rvalid_o) === 1'b1;
      q = rdata_o;
      s = w ? bresp_o : rresp_o;
      @(posedge clk_i);
      if (pa && ta) begin
        pa = 0;
        awvalid_i <= 1'b0;
        arvalid_i <= 1'b0;
      end
      if (pw && tw) begin
        pw = 0;
        wvalid_i <= 1'b0;
      end
      if (rv) begin
        dn = 1;
        bready_i <= 1'b0;
        rready_i <= 1'b0;
      end
    end
    if (!dn) begin
      ck("handshake", 32'h1, 32'h0);
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xf(1'b1, a, d);
    ck("bresp", 32'h0, {30'h0, s});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xf(1'b0, a, 32'h0);
    ck("rdata", e, q);
  endtask
  // pin: wait for level v, then count cycles it stays there
  task automatic run(input logic v, output int c);
    int n;
    for (n = 0; n < 200 && periodic_waveform_pin_o !== v; n++)
      @(negedge clk_i);
    if (n == 200) begin
      ck("pin_wait", 32'h1, 32'h0);
      summarize();
    end
    for (c = 0; c < 200 && periodic_waveform_pin_o === v; c++)
      @(negedge clk_i);
  endtask
  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    {srst_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = 6'h20;
    {awaddr_i, araddr_i, wdata_i, wstrb_i} = {16'h0, 32'h0, 4'hF};
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    foreach (rows[i]) begin
      xf(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) ck("rdata", rows[i].d, q);
      ck("resp", {30'h0, rows[i].r}, {30'h0, s});
    end
    wr(OFF_RATE, 32'h0);
    wr(OFF_CTRL, 32'h9E);
    run(0, h);
    run(1, h);
    run(0, l);
    ck("irq", 32'h1, {31'h0, irq_o});
    ck("toggle_hi", 32'h2, 32'(h));
    ck("toggle_lo", 32'h2, 32'(l));
    wr(OFF_RATE, 32'h3);
    wr(OFF_CTRL, 32'h8E);
    run(0, h);
    run(1, h);
    run(0, l);
    ck("pulse_hi", 32'h1, 32'(h));
    ck("pulse_lo", 32'h7, 32'(l));
    wr(OFF_CTRL, 32'h0);
    rd(OFF_CTRL, 32'h81);
    wr(OFF_CTRL, 32'h0);
    rd(OFF_CTRL, 32'h01);
    wr(OFF_CTRL, 32'hE);
    run(0, h);
    run(1, h);
    run(0, l);
    ck("aclk_hi", 32'h2, 32'(h));
    ck("aclk_lo", 32'hE, 32'(l));
    wr(OFF_CTRL, 32'h2);
    rd(OFF_STATUS, 32'h1);
    @(negedge clk_i);
    ck("pin", 32'h0, {31'h0, periodic_waveform_pin_o});
    ck("irq", 32'h1, {31'h0, irq_o});
    wr(OFF_CTRL, 32'h0);
    @(negedge clk_i);
    ck("irq", 32'h0, {31'h0, irq_o});
    wr(OFF_STATUS, 32'h0);
    rd(OFF_STATUS, 32'h1);
    wr(OFF_STATUS, 32'h1);
    rd(OFF_STATUS, 32'h0);
    wr(OFF_CTRL, 32'h4);
    h = 0;
    repeat (40) begin
      @(negedge clk_i);
      if (periodic_waveform_pin_o !== 1'b0) h++;
    end
    ck("noext", 32'h0, 32'(h));
    rd(OFF_STATUS, 32'h1);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(OFF_CTRL, 32'h0);
    rd(OFF_STATUS, 32'h0);
    summarize();
  end
endmodule
